// file: port_cfg_consts.svh
`ifndef PORT_CFG_CONSTS_SVH
`define PORT_CFG_CONSTS_SVH

`define PORT2_DRIVE_ADDR    8'hA6
`define PORT3_DRIVE_ADDR    8'hAE
`define PORT3_DATA_ADDR     8'hB0
`define PORT2_BYPASS_ADDR   8'hD6
`define PORT3_ANALOG_ADDR   8'hF4
`define CONFIG_PAGE         8'h0F
`define PORT2_DRIVE_RESET   8'h00
`define PORT3_DRIVE_RESET   8'h00
`define PORT3_DATA_RESET    8'hFF
`define PORT2_BYPASS_RESET  8'h00
`define PORT3_ANALOG_RESET  8'hFF
`define PORT2_ANALOG_RESET  8'hFF

`endif

// file: port_cfg_pkg.sv
`default_nettype none
package port_cfg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic       bit_val;
    logic [7:0] wdata;
    logic [7:0] page;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] p2_drive;
    logic [7:0] p3_drive;
    logic [7:0] p3_latch;
    logic [7:0] p2_bypass;
    logic [7:0] p3_analog;
    logic [7:0] rdata;
    logic       rvalid;
    logic [7:0] p3_out;
    logic [7:0] p3_oe;
    logic [7:0] p3_pullup;
    logic [7:0] p3_rx_en;
    logic [7:0] p2_push_pull;
  } port_state_t;

endpackage
`default_nettype wire

// file: port_pin_config_bank.sv
// Function
// R1 - output-mode bit n controls pin n of its port, bits 7..0 to pins 7..0
// R2 - output-mode bit 0 gives open-drain driver, 1 gives push-pull
// R3 - output-mode bit ignored while matching analog-select bit is 0
// R4 - port3 analog-select 0 makes pin analog, 1 keeps it digital
// R5 - analog pin loses weak pull-up and digital input receiver
// R6 - software must set analog pins to open-drain as well
// R7 - bypass bit 1 makes crossbar skip the port2 pin, 0 leaves it available
// R8 - software should set bypass bits for analog, special or GPIO pins
// R9 - writing port3 data loads output latch, 0 low, 1 high
// R10 - reading port3 data returns sampled pin levels of digital pins
// R11 - port3 data decoded on every page, with single-bit writes
// R12 - configuration registers respond only on configuration page
// R13 - open-drain pulls low on latch 0, releases pin on latch 1
`include "port_cfg_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module port_pin_config_bank
  import port_cfg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // special-function-register bus
  input  wire sfr_req_t         req,
  output logic [WIDTH-1:0]      rdata,
  output logic                  rvalid,
  // port 2 analog selection, held outside this block
  input  wire logic [WIDTH-1:0] port2_analog_select,
  // port 3 pins
  input  wire logic [WIDTH-1:0] p3_pin_in,
  output logic [WIDTH-1:0]      p3_pin_out,
  output logic [WIDTH-1:0]      p3_pin_oe,
  output logic [WIDTH-1:0]      p3_pullup_en,
  output logic [WIDTH-1:0]      p3_rx_en,
  // configuration seen by port 2 drivers and the crossbar
  output logic [WIDTH-1:0]      p2_push_pull,
  output logic [WIDTH-1:0]      port2_crossbar_bypass
);

  port_state_t s;
  port_state_t next_s;
  logic        cfg_page;
  logic [7:0]  p3_read;

  function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] idx, input logic v);
    logic [7:0] r;
    r = old;
    r[idx] = v;
    return r;
  endfunction

  // R13 open-drain enables the driver only for a low; R2 push-pull always drives
  function automatic logic [7:0] pin_enable(input logic [7:0] latch, input logic [7:0] drive, input logic [7:0] ana);
    return (drive & ana) | ~latch;
  endfunction

  // R3 drive type counts only on digital pins
  function automatic logic [7:0] pin_value(input logic [7:0] latch, input logic [7:0] drive, input logic [7:0] ana);
    return latch & drive & ana;
  endfunction

  always_comb begin
    next_s = s;
    // R12 configuration page gate
    cfg_page = (req.page == `CONFIG_PAGE);
    // R10 digital pins return pin level, analog pins read 0
    p3_read = p3_pin_in & s.p3_analog;
    next_s.rvalid = req.rd;
    next_s.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `PORT3_DATA_ADDR:   next_s.rdata = p3_read;
        `PORT2_DRIVE_ADDR:  next_s.rdata = cfg_page ? s.p2_drive : 8'h00;
        `PORT3_DRIVE_ADDR:  next_s.rdata = cfg_page ? s.p3_drive : 8'h00;
        `PORT2_BYPASS_ADDR: next_s.rdata = cfg_page ? s.p2_bypass : 8'h00;
        `PORT3_ANALOG_ADDR: next_s.rdata = cfg_page ? s.p3_analog : 8'h00;
        default:            next_s.rdata = 8'h00;
      endcase
    end
    // R9 latch load; R11 any page, bit access
    if (req.wr && req.addr == `PORT3_DATA_ADDR) begin
      next_s.p3_latch = req.wdata;
    end else if (req.bit_wr && req.addr == `PORT3_DATA_ADDR) begin
      next_s.p3_latch = bit_merge(s.p3_latch, req.bit_sel, req.bit_val);
    end
    if (req.wr && cfg_page) begin
      case (req.addr)
        `PORT2_DRIVE_ADDR:  next_s.p2_drive = req.wdata;
        `PORT3_DRIVE_ADDR:  next_s.p3_drive = req.wdata;
        `PORT2_BYPASS_ADDR: next_s.p2_bypass = req.wdata;
        `PORT3_ANALOG_ADDR: next_s.p3_analog = req.wdata;
        default:            next_s.p3_analog = s.p3_analog;
      endcase
    end
    // R1 R2 R3 push-pull only on digital pins with drive bit set
    next_s.p2_push_pull = next_s.p2_drive & port2_analog_select;
    // R13 open-drain drives only low; R2 push-pull drives both levels
    next_s.p3_out = pin_value(next_s.p3_latch, next_s.p3_drive, next_s.p3_analog);
    next_s.p3_oe = pin_enable(next_s.p3_latch, next_s.p3_drive, next_s.p3_analog);
    // R4 R5 analog pins lose pull-up and receiver
    next_s.p3_pullup = next_s.p3_analog;
    next_s.p3_rx_en = next_s.p3_analog;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s.p2_drive     <= `PORT2_DRIVE_RESET;
      s.p3_drive     <= `PORT3_DRIVE_RESET;
      s.p3_latch     <= `PORT3_DATA_RESET;
      s.p2_bypass    <= `PORT2_BYPASS_RESET;
      s.p3_analog    <= `PORT3_ANALOG_RESET;
      s.rdata        <= 8'h00;
      s.rvalid       <= 1'b0;
      s.p3_out       <= 8'h00;
      s.p3_oe        <= 8'h00;
      s.p3_pullup    <= 8'hFF;
      s.p3_rx_en     <= 8'hFF;
      s.p2_push_pull <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign rvalid = s.rvalid;
  assign p3_pin_out = s.p3_out;
  assign p3_pin_oe = s.p3_oe;
  assign p3_pullup_en = s.p3_pullup;
  assign p3_rx_en = s.p3_rx_en;
  assign p2_push_pull = s.p2_push_pull;
  // R7 skip bits go straight to the crossbar
  assign port2_crossbar_bypass = s.p2_bypass;

  // R13 latch 0 always pulls low
  od_low_a: assert property (@(posedge mclk) disable iff (rst)
    !s.p3_latch[0] |-> s.p3_oe[0] && !s.p3_out[0]) else $error("latch low not driven"); // R13
  // R13 open-drain high releases pin
  od_release_a: assert property (@(posedge mclk) disable iff (rst)
    s.p3_latch[1] && !s.p3_drive[1] |-> !s.p3_oe[1]) else $error("open-drain high driven"); // R13
  // R3 analog pin never push-pull
  analog_ignore_a: assert property (@(posedge mclk) disable iff (rst)
    !s.p3_analog[2] && s.p3_latch[2] |-> !s.p3_oe[2]) else $error("analog pin driven high"); // R3
  // R5 analog pin loses pull-up
  analog_pull_a: assert property (@(posedge mclk) disable iff (rst)
    (s.p3_pullup == s.p3_analog) && (s.p3_rx_en == s.p3_analog)) else $error("pull-up mismatch"); // R5
  // R9 data write loads latch
  data_write_a: assert property (@(posedge mclk) disable iff (rst)
    req.wr && req.addr == `PORT3_DATA_ADDR |=> s.p3_latch == $past(req.wdata)) else $error("latch not loaded"); // R9
  // R11 bit write touches one bit
  bit_write_a: assert property (@(posedge mclk) disable iff (rst)
    req.bit_wr && !req.wr && req.addr == `PORT3_DATA_ADDR |=> s.p3_latch[$past(req.bit_sel)] == $past(req.bit_val))
    else $error("bit write lost"); // R11
  // R12 off-page write ignored
  page_gate_a: assert property (@(posedge mclk) disable iff (rst)
    req.wr && req.page != `CONFIG_PAGE |=> $stable(s.p2_bypass) && $stable(s.p3_drive)) else $error("off-page write"); // R12
  // R10 read returns pins
  read_pins_a: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.addr == `PORT3_DATA_ADDR |=> rvalid && rdata == ($past(p3_pin_in) & $past(s.p3_analog)))
    else $error("read not pin level"); // R10
  // R2 push-pull drives high
  push_high_a: assert property (@(posedge mclk) disable iff (rst)
    s.p3_drive[3] && s.p3_analog[3] && s.p3_latch[3] |-> s.p3_oe[3] && s.p3_out[3]) else $error("push-pull not high"); // R2

  // R10 read answered one cycle later
  rvalid_follow_a: assert property (@(posedge mclk) disable iff (rst)
    req.rd |=> rvalid) else $error("read not answered"); // R10

  // R10 no answer without a read
  rvalid_drop_a: assert property (@(posedge mclk) disable iff (rst)
    !req.rd |=> !rvalid) else $error("spurious read answer"); // R10

  // R12 off-page config read gives zero
  off_page_read_a: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.page != `CONFIG_PAGE && req.addr == `PORT2_BYPASS_ADDR |=> rdata == 8'h00)
    else $error("off-page read not zero"); // R12

  // R12 on-page config read returns register
  cfg_read_a: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.page == `CONFIG_PAGE && req.addr == `PORT3_ANALOG_ADDR |=> rdata == $past(s.p3_analog))
    else $error("config read wrong"); // R12

  // R7 bypass write reaches crossbar
  bypass_load_a: assert property (@(posedge mclk) disable iff (rst)
    req.wr && req.page == `CONFIG_PAGE && req.addr == `PORT2_BYPASS_ADDR |=> port2_crossbar_bypass == $past(req.wdata))
    else $error("bypass not loaded"); // R7

  // R2 drive type write lands
  drive_load_a: assert property (@(posedge mclk) disable iff (rst)
    req.wr && req.page == `CONFIG_PAGE && req.addr == `PORT2_DRIVE_ADDR |=> s.p2_drive == $past(req.wdata))
    else $error("drive type not loaded"); // R2

  // R3 port2 drive type masked by analog select
  p2_type_a: assert property (@(posedge mclk) disable iff (rst)
    p2_push_pull == (s.p2_drive & $past(port2_analog_select))) else $error("port2 drive type wrong"); // R3

  // R1 every pin value follows its own bits
  pin_value_a: assert property (@(posedge mclk) disable iff (rst)
    p3_pin_out == (s.p3_latch & s.p3_drive & s.p3_analog)) else $error("pin value wrong"); // R1

  // R13 every pin enable follows its own bits
  pin_enable_a: assert property (@(posedge mclk) disable iff (rst)
    p3_pin_oe == ((s.p3_drive & s.p3_analog) | ~s.p3_latch)) else $error("pin enable wrong"); // R13

  // R11 bit write leaves other bits alone
  bit_keep_a: assert property (@(posedge mclk) disable iff (rst)
    req.bit_wr && !req.wr && req.addr == `PORT3_DATA_ADDR |=>
    (s.p3_latch | (8'h01 << $past(req.bit_sel))) == ($past(s.p3_latch) | (8'h01 << $past(req.bit_sel))))
    else $error("bit write disturbed others"); // R11

  // R4 reset leaves pins digital with latch high
  reset_state_a: assert property (@(posedge mclk)
    rst |=> s.p3_latch == `PORT3_DATA_RESET && s.p3_analog == `PORT3_ANALOG_RESET && s.p2_drive == `PORT2_DRIVE_RESET)
    else $error("reset state wrong"); // R4

  // R5 analog pin reads zero
  analog_read_a: assert property (@(posedge mclk) disable iff (rst)
    req.rd && req.addr == `PORT3_DATA_ADDR && !s.p3_analog[5] |=> !rdata[5])
    else $error("analog pin read as digital"); // R5

  cover_bypass_c: cover property (@(posedge mclk) req.wr && cfg_page && req.addr == `PORT2_BYPASS_ADDR);
  cover_bitwr_c: cover property (@(posedge mclk) req.bit_wr && req.addr == `PORT3_DATA_ADDR);
  cover_analog_c: cover property (@(posedge mclk) s.p3_analog != 8'hFF);
  cover_offpage_c: cover property (@(posedge mclk) req.wr && !cfg_page);
  cover_read_c: cover property (@(posedge mclk) rvalid && rdata != 8'h00);

endmodule

`default_nettype wire

// file: pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] drive_out,
  input  wire logic [7:0] drive_oe,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      level
);
  logic [7:0] flip = 8'h55;
  // a pin nobody drives or pulls up wanders every cycle
  always @(posedge clk) flip <= ~flip;
  // device driver wins, then outside driver, then pull-up
  always_comb level = drive_oe & drive_out | ~drive_oe & (ext_en & ext_val | ~ext_en & (pull_en | flip));
endmodule
`default_nettype wire

// file: tb_port_pin_config_bank.sv
`timescale 1ns/100ps
`default_nettype none
module tb_port_pin_config_bank import port_cfg_pkg::*; ;
  logic mclk = 0, rst = 1, rvalid;
  sfr_req_t req = '0;
  logic [7:0] rdata, oe, out, pu, rx, pp, byp, lvl, pg;
  logic [7:0] d2 = 0, d3 = 0, lt = 8'hFF, bp = 0, an = 8'hFF, p2a = 8'hFF, ee = 0, ev = 0;
  logic [7:0] adr [6] = '{8'hA6, 8'hAE, 8'hB0, 8'hD6, 8'hF4, 8'hA7};
  logic [7:0] q [$];
  int miscompares = 0, samples_checked = 0, cyc = 0;
  initial forever #10 mclk = ~mclk;
  port_pin_config_bank dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .port2_analog_select(p2a), .p3_pin_in(lvl), .p3_pin_out(out), .p3_pin_oe(oe), .p3_pullup_en(pu),
    .p3_rx_en(rx), .p2_push_pull(pp), .port2_crossbar_bypass(byp));
  pad_model pads (.clk(mclk), .drive_out(out), .drive_oe(oe), .pull_en(pu), .ext_en(ee), .ext_val(ev),
    .level(lvl));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, r, b, input logic [7:0] a, d, p, input logic [2:0] s = 0);
    req <= '{wr:w, rd:r, bit_wr:b, addr:a, bit_sel:s, bit_val:d[0], wdata:d, page:p};
    @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, d, p);
    bus(1, 0, 0, a, d, p);
    if (p == 8'h0F) case (a)
      8'hA6: d2 = d;
      8'hAE: d3 = d;
      8'hD6: bp = d;
      8'hF4: an = d;
    endcase
    if (a == 8'hB0) lt = d;
  endtask
  function automatic logic [7:0] rexp(input logic [7:0] a, p);
    logic [7:0] e;
    e = d3 & an | ~lt;
    if (a == 8'hB0) return (e & lt & d3 & an | ~e & (ee & ev | ~ee)) & an;
    if (p != 8'h0F) return 8'h00;
    case (a)
      8'hA6: return d2;
      8'hAE: return d3;
      8'hD6: return bp;
      8'hF4: return an;
      default: return 8'h00;
    endcase
  endfunction
  task automatic outs;
    bus(0, 0, 0, 0, 0, 0);
    @(negedge mclk);
    chk(pp, d2 & p2a);
    chk(oe, d3 & an | ~lt);
    chk(out, lt & d3 & an);
    chk(pu, an);
    chk(rx, an);
    chk(byp, bp);
  endtask
  task automatic rd_all(input logic [7:0] p);
    foreach (adr[i]) begin
      q.push_back(rexp(adr[i], p));
      bus(0, 1, 0, adr[i], 0, p);
    end
    outs();
  endtask
  always @(negedge mclk) if (rvalid === 1'b1) chk(rdata, q.pop_front());
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(61));
    repeat (4) @(negedge mclk);
    rst <= 0;
    @(negedge mclk);
    rd_all(8'h0F);
    rd_all(8'h00);
    repeat (25) begin
      {p2a, ee, ev} = 24'($urandom);
      pg = ($urandom % 3 == 0) ? 8'h00 : 8'h0F;
      foreach (adr[i]) wr(adr[i], 8'($urandom), pg);
      // analog pins open-drain, used pins skipped
      wr(8'hAE, d3 & an, 8'h0F);
      wr(8'hD6, bp | ~an, 8'h0F);
      repeat (3) begin
        pg[2:0] = 3'($urandom);
        ev[7] = 1'($urandom);
        bus(0, 0, 1, 8'hB0, {7'h00, ev[7]}, {4'h0, pg[3:0]}, pg[2:0]);
        lt[pg[2:0]] = ev[7];
      end
      rd_all(pg);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
